// >>> logic/pmd_pkg.sv
// Shared constants, field layout and carrier types of the PCI/memory DMA engine
package pmd_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam int unsigned NCH = 4;
	localparam logic [7:0] OFS_CTL0 = 8'h38;
	localparam logic [7:0] OFS_CTL1 = 8'h44;
	localparam logic [7:0] OFS_CTL2 = 8'hA4;
	localparam logic [7:0] OFS_CTL3 = 8'hB0;
	localparam logic [7:0] OFS_CHAIN = 8'h80;
	localparam logic [7:0] OFS_REMAIN = 8'h64;
	localparam logic [7:0] OFS_CUR_MEM = 8'h68;
	localparam logic [7:0] OFS_CUR_PCI = 8'h6C;
	localparam logic [7:0] OFS_MADDR0 = 8'hC0;
	localparam logic [7:0] OFS_PADDR0 = 8'hC4;
	localparam logic [7:0] OFS_NEXT0 = 8'hC8;
	localparam logic [7:0] OFS_STRIDE = 8'h10;

	// ************************************************************
	// Control field positions and reset values
	// ************************************************************
	localparam int unsigned CTL_LEN_LSB = 0;
	localparam int unsigned CTL_LEN_W = 20;
	localparam int unsigned CTL_BND_LSB = 20;
	localparam int unsigned CTL_BND_W = 4;
	localparam int unsigned CTL_RST = 24;
	localparam int unsigned CTL_MIO = 25;
	localparam int unsigned CTL_INC = 26;
	localparam int unsigned CTL_SUS = 27;
	localparam int unsigned CTL_GO = 28;
	localparam int unsigned CTL_DIR = 29;
	localparam int unsigned CTL_IE = 30;
	localparam int unsigned CTL_BUSY = 31;
	localparam int unsigned CHAIN_LSB = 8;
	localparam logic [30:0] CTL_RESET = 31'h0000_0000;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

	// ************************************************************
	// Sizes and thresholds
	// ************************************************************
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned LVL_W = 4;
	localparam logic [3:0] LVL_FULL = 4'h8;
	localparam logic [3:0] LVL_HALF = 4'h4;
	localparam logic [3:0] LVL_ONE = 4'h1;
	localparam int unsigned WORDS_W = 19;
	localparam logic [18:0] WORDS_MAX = 19'h40000;
	localparam int unsigned BND_BASE_LOG2 = 5;
	localparam logic [1:0] REC_LAST = 2'h3;
	localparam logic [31:0] REC_ALIGN = 32'hFFFF_FFF0;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		PMD_IDLE = 4'b0001,
		PMD_LOAD = 4'b0010,
		PMD_RUN = 4'b0100,
		PMD_FETCH = 4'b1000
	} pmd_state_t;

	typedef struct packed {
		logic pclk;
		logic gnt;
		logic ack;
		logic mabort;
		logic tabort;
		logic [31:0] rdata;
	} pmd_pci_in_t;

	typedef struct packed {
		logic req;
		logic write;
		logic mem_space;
		logic disconnect;
		logic [31:0] addr;
		logic [31:0] wdata;
	} pmd_pci_out_t;

	typedef struct packed {
		logic gnt;
		logic ack;
		logic [31:0] rdata;
	} pmd_mem_in_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} pmd_mem_out_t;

endpackage : pmd_pkg

// >>> logic/pmd_fifo.sv
// Flip-flop FIFO that carries DMA words between the PCI and memory sides
`timescale 1ns/1ps
`default_nettype none
module pmd_fifo
	import pmd_pkg::*;
#(
	parameter int unsigned W = 32,
	parameter int unsigned DEPTH = FIFO_DEPTH,
	parameter int unsigned LW = LVL_W
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic flush,
	input wire logic push,
	input wire logic [W-1:0] wdata,
	input wire logic pop,
	output logic [W-1:0] head,
	output logic [LW-1:0] level
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [LW-1:0] cnt;
	} pmd_fifo_state_t;

	pmd_fifo_state_t s_q;
	pmd_fifo_state_t s_d;
	logic do_push;
	logic do_pop;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		// Overflow and underflow requests are dropped, not wrapped
		do_push = push && (s_q.cnt != LW'(DEPTH));
		do_pop = pop && (s_q.cnt != '0);
		if (do_push) begin
			s_d.mem[s_q.wr] = wdata;
			s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + AW'(1);
		end
		if (do_pop) begin
			s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + AW'(1);
		end
		if (do_push && !do_pop) begin
			s_d.cnt = s_q.cnt + LW'(1);
		end else if (do_pop && !do_push) begin
			s_d.cnt = s_q.cnt - LW'(1);
		end
		if (flush) begin
			s_d.rd = '0;
			s_d.wr = '0;
			s_d.cnt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign head = s_q.mem[s_q.rd];
	assign level = s_q.cnt;

endmodule : pmd_fifo
`default_nettype wire

// >>> logic/pmd_dma.sv
// Four-channel DMA engine between local memory and a PCI master port
//
// Behaviour
// - Direction bit 29 one moves PCI to memory, zero moves memory to PCI.
// - PCI-to-memory fills from PCI first, drains to memory once four words held.
// - PCI-to-memory source released when FIFO full, retaken at four words.
// - Memory-to-PCI starts by reading memory to fill eight words.
// - Memory-to-PCI requests PCI at four words, drains while refilling.
// - Memory-to-PCI releases memory when full, refills again at four words.
// - Empty FIFO toward PCI disconnects; PCI retaken after one or four words.
// - After last memory read, keep draining to PCI until final transfer.
// - Completion with interrupt enabled flags that channel's done status.
// - Before next transfer, let pending CPU memory and PCI transactions finish.
// - Chaining with nonzero next address fetches and starts next record.
// - With chaining, completion flag comes only after last record.
// - PCI abort resets channel, reports abort type and flags bus error.
// - After bus error, other channels with go set are started.
// - During transfer CPU memory access allowed once per boundary point.
// - Posted CPU memory write stalls CPU completion until boundary or end.
// - CPU PCI reads and posted PCI writes stall CPU during transfer.
// - Four register sets; idle sets stay readable and writable.
// - Started channel ignores control writes except reset and pause bits.
// - Length in bytes in bits 19:0, zero meaning one megabyte.
// - Boundary code zero none, one 32 bytes, doubling up to 512K.
// - Reset bit aborts after current cycle, overrides all, clears itself.
// - Go bit starts transfer, cleared by hardware, software clear ignored.
// - Pause bit halts after current PCI cycle; clearing resumes.
// - Completion interrupt enable bit 30 gates completion flag.
// - Read-only bit 31 shows transfer in progress.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pmd_dma
	import pmd_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire pmd_pci_in_t pci_in,
	output pmd_pci_out_t pci_out,
	input wire pmd_mem_in_t mem_in,
	output pmd_mem_out_t mem_out,
	input wire logic mem_single_word,
	input wire logic cpu_mem_rd_req,
	input wire logic cpu_wfifo_posted,
	input wire logic cpu_mem_taken,
	input wire logic cpu_pci_rd_req,
	input wire logic pci_mfifo_busy,
	input wire logic cpu_ready,
	output logic cpu_cycle_done_n,
	output logic cpu_mem_window,
	output logic [NCH-1:0] chan_done,
	output logic bus_error,
	output logic [1:0] bus_error_type
);

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic [18:0] pmd_words(input logic [19:0] len);
		logic [20:0] sum;
		sum = {1'b0, len} + 21'h3;
		if (len == 20'h0) begin
			return WORDS_MAX;
		end
		return sum[20:2];
	endfunction : pmd_words

	function automatic logic pmd_bnd_hit(input logic [3:0] code, input logic [31:0] addr);
		logic [19:0] mask;
		mask = (20'h1 << (BND_BASE_LOG2 - 1 + 32'(code))) - 20'h1;
		return (code != 4'h0) && ((addr[19:0] & mask) == 20'h0);
	endfunction : pmd_bnd_hit

	// Rotating pick so that a busy channel cannot starve the others
	function automatic logic [2:0] pmd_pick(input logic [NCH-1:0] pend, input logic [1:0] last);
		logic [2:0] res;
		logic [1:0] idx;
		res = 3'h0;
		idx = 2'h0;
		for (int k = NCH; k >= 1; k--) begin
			idx = last + 2'(k);
			if (pend[idx]) begin
				res = {1'b1, idx};
			end
		end
		return res;
	endfunction : pmd_pick

	function automatic logic [2:0] pmd_ctl_sel(input logic [7:0] a);
		unique case (a)
			OFS_CTL0: return 3'h4;
			OFS_CTL1: return 3'h5;
			OFS_CTL2: return 3'h6;
			OFS_CTL3: return 3'h7;
			default: return 3'h0;
		endcase
	endfunction : pmd_ctl_sel

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [NCH-1:0][30:0] ctl;
		logic [NCH-1:0][31:0] maddr;
		logic [NCH-1:0][31:0] paddr;
		logic [NCH-1:0][31:0] nxt;
		logic [NCH-1:0] chain;
		pmd_state_t st;
		logic gap;
		logic [1:0] ch;
		logic [31:0] cur_mem;
		logic [31:0] cur_pci;
		logic [18:0] mem_left;
		logic [18:0] pci_left;
		logic fill_en;
		logic drain_en;
		logic refill;
		logic [1:0] rec_idx;
		logic win;
		pmd_pci_in_t s1;
		pmd_pci_in_t s2;
		pmd_pci_in_t s3;
		logic pclk_lvl;
		logic disc;
		logic [31:0] rdata;
		logic [NCH-1:0] done;
		logic berr;
		logic [1:0] berr_type;
	} pmd_state_s_t;

	pmd_state_s_t s_q;
	pmd_state_s_t s_d;

	logic [31:0] fifo_head;
	logic [LVL_W-1:0] lvl;
	logic fifo_push;
	logic fifo_pop;
	logic fifo_flush;
	logic [31:0] fifo_wdata;
	logic pedge;
	logic xfer_on;
	logic run;
	logic dir;
	logic sus;
	logic pci_req;
	logic mem_req;
	logic pci_xfer;
	logic mem_xfer;
	logic [NCH-1:0] busy;
	logic [NCH-1:0] pend;
	logic [2:0] pick;
	logic [2:0] csel;
	logic [3:0] thr;
	logic [1:0] c;

	pmd_fifo #(
		.W(32),
		.DEPTH(FIFO_DEPTH),
		.LW(LVL_W)
	) u_fifo (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.flush(fifo_flush),
		.push(fifo_push),
		.wdata(fifo_wdata),
		.pop(fifo_pop),
		.head(fifo_head),
		.level(lvl)
	);

	// ************************************************************
	// Datapath and sequencing
	// ************************************************************
	always_comb begin
		s_d = s_q;
		c = s_q.ch;
		s_d.done = '0;
		s_d.berr = 1'b0;
		s_d.disc = 1'b0;
		s_d.rdata = 32'h0000_0000;
		// Link pins through three stages; edges only count when stages two and three agree
		s_d.s1 = pci_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		if (s_q.s2.pclk == s_q.s3.pclk) begin
			s_d.pclk_lvl = s_q.s3.pclk;
		end
		pedge = s_q.s2.pclk && s_q.s3.pclk && !s_q.pclk_lvl;
		xfer_on = (s_q.st != PMD_IDLE);
		run = (s_q.st == PMD_RUN);
		dir = s_q.ctl[c][CTL_DIR];
		sus = s_q.ctl[c][CTL_SUS];
		for (int i = 0; i < NCH; i++) begin
			busy[i] = xfer_on && (s_q.ch == 2'(i));
			pend[i] = s_q.ctl[i][CTL_GO] && !s_q.ctl[i][CTL_RST];
		end
		pick = pmd_pick(pend, s_q.ch);
		thr = (s_q.refill && mem_single_word) ? LVL_ONE : LVL_HALF;

		// Pause gates word requests in RUN only; record reads in FETCH still go out
		if (dir) begin
			pci_req = run && !sus && s_q.fill_en && (s_q.pci_left != '0) && (lvl != LVL_FULL);
			mem_req = run && !sus && (lvl != 4'h0)
				&& ((lvl >= LVL_HALF) || (s_q.pci_left == '0));
		end else begin
			pci_req = run && !sus && s_q.drain_en && (lvl != 4'h0);
			mem_req = run && !sus && s_q.fill_en && (s_q.mem_left != '0) && (lvl != LVL_FULL);
		end
		if (s_q.st == PMD_FETCH) begin
			mem_req = 1'b1;
		end
		pci_xfer = pci_req && pedge && s_q.s3.gnt && s_q.s3.ack;
		mem_xfer = mem_req && mem_in.gnt && mem_in.ack;
		fifo_push = run && (dir ? pci_xfer : mem_xfer);
		fifo_pop = run && (dir ? mem_xfer : pci_xfer);
		fifo_wdata = dir ? s_q.s3.rdata : mem_in.rdata;
		fifo_flush = 1'b0;

		// Channel reset of a channel that is not running
		for (int i = 0; i < NCH; i++) begin
			if (s_q.ctl[i][CTL_RST] && !busy[i]) begin
				s_d.ctl[i][CTL_RST] = 1'b0;
				s_d.ctl[i][CTL_GO] = 1'b0;
			end
		end

		unique case (s_q.st)
			PMD_IDLE: begin
				// Hold off until posted CPU work has drained
				if (s_q.gap) begin
					if (!cpu_wfifo_posted && !pci_mfifo_busy) begin
						s_d.gap = 1'b0;
					end
				end else if (pick[2]) begin
					s_d.ch = pick[1:0];
					s_d.st = PMD_LOAD;
				end
			end
			PMD_LOAD: begin
				s_d.cur_mem = s_q.maddr[c];
				s_d.cur_pci = s_q.paddr[c];
				s_d.mem_left = pmd_words(s_q.ctl[c][CTL_LEN_LSB +: CTL_LEN_W]);
				s_d.pci_left = pmd_words(s_q.ctl[c][CTL_LEN_LSB +: CTL_LEN_W]);
				s_d.fill_en = 1'b1;
				s_d.drain_en = 1'b0;
				s_d.refill = 1'b0;
				s_d.win = 1'b0;
				fifo_flush = 1'b1;
				s_d.st = PMD_RUN;
			end
			PMD_RUN: begin
				if (lvl == LVL_FULL) begin
					s_d.fill_en = 1'b0;
				end else if (lvl <= LVL_HALF) begin
					s_d.fill_en = 1'b1;
				end
				if (!dir) begin
					if (!s_q.drain_en && (lvl >= thr || (s_q.mem_left == '0 && lvl != 4'h0))) begin
						s_d.drain_en = 1'b1;
					end else if (s_q.drain_en && lvl == 4'h0 && s_q.pci_left != '0) begin
						s_d.drain_en = 1'b0;
						s_d.disc = 1'b1;
						s_d.refill = 1'b1;
					end
				end
				if (mem_xfer) begin
					s_d.mem_left = s_q.mem_left - 19'h1;
					s_d.cur_mem = s_q.cur_mem + WORD_BYTES;
					if (pmd_bnd_hit(s_q.ctl[c][CTL_BND_LSB +: CTL_BND_W], s_q.cur_mem + WORD_BYTES)) begin
						s_d.win = 1'b1;
					end
				end
				if (pci_xfer) begin
					s_d.pci_left = s_q.pci_left - 19'h1;
					if (s_q.ctl[c][CTL_INC]) begin
						s_d.cur_pci = s_q.cur_pci + WORD_BYTES;
					end
				end
				if (pedge && (s_q.s3.mabort || s_q.s3.tabort)) begin
					s_d.berr = 1'b1;
					s_d.berr_type = {s_q.s3.tabort, s_q.s3.mabort};
					s_d.ctl[c][CTL_GO] = 1'b0;
					s_d.ctl[c][CTL_RST] = 1'b0;
					fifo_flush = 1'b1;
					s_d.st = PMD_IDLE;
					s_d.gap = 1'b1;
				end else if (s_q.ctl[c][CTL_RST] && !pci_xfer && !mem_xfer) begin
					s_d.ctl[c][CTL_GO] = 1'b0;
					s_d.ctl[c][CTL_RST] = 1'b0;
					fifo_flush = 1'b1;
					s_d.st = PMD_IDLE;
					s_d.gap = 1'b1;
				end else if (s_q.mem_left == '0 && s_q.pci_left == '0 && lvl == 4'h0) begin
					if (s_q.chain[c] && s_q.nxt[c] != 32'h0000_0000) begin
						s_d.cur_mem = s_q.nxt[c] & REC_ALIGN;
						s_d.rec_idx = 2'h0;
						s_d.st = PMD_FETCH;
					end else begin
						s_d.ctl[c][CTL_GO] = 1'b0;
						s_d.done[c] = s_q.ctl[c][CTL_IE];
						s_d.st = PMD_IDLE;
						s_d.gap = 1'b1;
					end
				end
			end
			PMD_FETCH: begin
				if (mem_xfer) begin
					unique case (s_q.rec_idx)
						2'h0: s_d.ctl[c] = (mem_in.rdata[30:0] & ~(31'h1 << CTL_RST))
							| (31'h1 << CTL_GO);
						2'h1: s_d.maddr[c] = mem_in.rdata;
						2'h2: s_d.paddr[c] = mem_in.rdata;
						2'h3: s_d.nxt[c] = mem_in.rdata;
					endcase
					s_d.cur_mem = s_q.cur_mem + WORD_BYTES;
					s_d.rec_idx = s_q.rec_idx + 2'h1;
					if (s_q.rec_idx == REC_LAST) begin
						s_d.st = PMD_LOAD;
					end
				end
			end
		endcase

		// The CPU consumes the boundary window; a new hit in that cycle wins
		if (cpu_mem_taken && !(run && mem_xfer
			&& pmd_bnd_hit(s_q.ctl[c][CTL_BND_LSB +: CTL_BND_W], s_q.cur_mem + WORD_BYTES))) begin
			s_d.win = 1'b0;
		end

		// Software writes come last so a written reset bit survives a hardware clear
		csel = pmd_ctl_sel(reg_addr);
		if (reg_wr) begin
			if (csel[2]) begin
				if (busy[csel[1:0]]) begin
					s_d.ctl[csel[1:0]][CTL_SUS] = reg_wdata[CTL_SUS];
					if (reg_wdata[CTL_RST]) begin
						s_d.ctl[csel[1:0]][CTL_RST] = 1'b1;
					end
				end else if (reg_wdata[CTL_RST]) begin
					s_d.ctl[csel[1:0]][CTL_RST] = 1'b1;
				end else begin
					s_d.ctl[csel[1:0]] = reg_wdata[30:0];
					s_d.ctl[csel[1:0]][CTL_GO] = reg_wdata[CTL_GO]
						|| (s_q.ctl[csel[1:0]][CTL_GO]
						&& !s_q.ctl[csel[1:0]][CTL_RST]);
				end
			end
			if (reg_addr == OFS_CHAIN) begin
				s_d.chain = reg_wdata[CHAIN_LSB +: NCH];
			end
			for (int i = 0; i < NCH; i++) begin
				if (!busy[i]) begin
					if (reg_addr == OFS_MADDR0 + 8'(i * 16)) begin
						s_d.maddr[i] = reg_wdata;
					end
					if (reg_addr == OFS_PADDR0 + 8'(i * 16)) begin
						s_d.paddr[i] = reg_wdata;
					end
					if (reg_addr == OFS_NEXT0 + 8'(i * 16)) begin
						s_d.nxt[i] = reg_wdata;
					end
				end
			end
		end

		// Unmapped reads return zero
		if (reg_rd) begin
			if (csel[2]) begin
				s_d.rdata = {busy[csel[1:0]], s_q.ctl[csel[1:0]]};
			end
			unique case (reg_addr)
				OFS_CHAIN: s_d.rdata = 32'(s_q.chain) << CHAIN_LSB;
				OFS_REMAIN: s_d.rdata = {13'h0000, s_q.pci_left};
				OFS_CUR_MEM: s_d.rdata = s_q.cur_mem;
				OFS_CUR_PCI: s_d.rdata = s_q.cur_pci;
				default: begin
				end
			endcase
			for (int i = 0; i < NCH; i++) begin
				if (reg_addr == OFS_MADDR0 + 8'(i * 16)) begin
					s_d.rdata = s_q.maddr[i];
				end
				if (reg_addr == OFS_PADDR0 + 8'(i * 16)) begin
					s_d.rdata = s_q.paddr[i];
				end
				if (reg_addr == OFS_NEXT0 + 8'(i * 16)) begin
					s_d.rdata = s_q.nxt[i];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.st <= PMD_IDLE;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign reg_rdata = s_q.rdata;
	assign pci_out.req = pci_req;
	assign pci_out.write = !dir;
	assign pci_out.mem_space = s_q.ctl[c][CTL_MIO];
	assign pci_out.disconnect = s_q.disc;
	assign pci_out.addr = s_q.cur_pci;
	assign pci_out.wdata = fifo_head;
	assign mem_out.req = mem_req;
	assign mem_out.we = run && dir;
	assign mem_out.addr = s_q.cur_mem;
	assign mem_out.wdata = fifo_head;
	assign chan_done = s_q.done;
	assign bus_error = s_q.berr;
	assign bus_error_type = s_q.berr_type;
	// Only RUN, LOAD and FETCH block the CPU; the gap between transfers is open
	assign cpu_mem_window = s_q.win || !xfer_on;
	assign cpu_cycle_done_n = !(cpu_ready && !(xfer_on && ((((cpu_mem_rd_req || cpu_wfifo_posted)
		&& !s_q.win)) || cpu_pci_rd_req || pci_mfifo_busy)));

endmodule : pmd_dma
`default_nettype wire

// >>> tb/pmd_dma_props.sv
// Port checker of the DMA engine
`timescale 1ns/1ps
`default_nettype none
module pmd_dma_props
	import pmd_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire pmd_pci_out_t pci_out,
	input wire pmd_mem_out_t mem_out,
	input wire logic cpu_mem_rd_req,
	input wire logic cpu_wfifo_posted,
	input wire logic cpu_pci_rd_req,
	input wire logic pci_mfifo_busy,
	input wire logic cpu_ready,
	input wire logic cpu_cycle_done_n,
	input wire logic cpu_mem_window,
	input wire logic [NCH-1:0] chan_done,
	input wire logic bus_error,
	input wire logic [1:0] bus_error_type
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_done_one; $onehot0(chan_done); endproperty
	a_done_one: assert property (p_done_one) else $error("two done flags");
	property p_err_pulse; bus_error |=> !bus_error; endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("error flag too long");
	property p_err_type; $rose(bus_error) |-> bus_error_type inside {2'h1, 2'h2}; endproperty
	a_err_type: assert property (p_err_type) else $error("bad abort type");
	property p_cpu_go;
		(cpu_ready && !cpu_pci_rd_req && !pci_mfifo_busy && !cpu_mem_rd_req
			&& !cpu_wfifo_posted) |-> !cpu_cycle_done_n;
	endproperty
	a_cpu_go: assert property (p_cpu_go) else $error("cpu stalled for nothing");
	property p_pci_stall; (cpu_pci_rd_req && !cpu_mem_window) |-> cpu_cycle_done_n; endproperty
	a_pci_stall: assert property (p_pci_stall) else $error("pci read not stalled");
	property p_mem_stall; (cpu_mem_rd_req && !cpu_mem_window) |-> cpu_cycle_done_n; endproperty
	a_mem_stall: assert property (p_mem_stall) else $error("mem read not stalled");
	property p_disc; $rose(pci_out.disconnect) |=> !pci_out.disconnect; endproperty
	a_disc: assert property (p_disc) else $error("disconnect too long");
	property p_dir; (mem_out.req && mem_out.we) |-> !pci_out.write; endproperty
	a_dir: assert property (p_dir) else $error("directions disagree");
endmodule : pmd_dma_props
`default_nettype wire

// >>> tb/pmd_far_model.sv
// Far side: PCI target on its own clock and a local memory port
`timescale 1ns/1ps
`default_nettype none
module pmd_far_model
	import pmd_pkg::*;
(
	input wire logic clk,
	input wire logic slow,
	input wire logic clr,
	input wire logic [1:0] abort_kind,
	input wire pmd_pci_out_t pci_out,
	input wire pmd_mem_out_t mem_out,
	output pmd_pci_in_t pci_in,
	output pmd_mem_in_t mem_in,
	output logic [31:0] mem_cnt
);
	logic pclk = 1'b0;
	logic pg = 1'b0;
	logic pa = 1'b0;
	logic [1:0] pab = 2'h0;
	logic [31:0] prd = 32'h0;
	logic gq = 1'b0;
	logic tick = 1'b0;
	logic mack;
	// PCI clock runs free
	always #40 pclk = !pclk;
	// Answers move on the falling edge so they stand still around the rising one
	always @(negedge pclk) begin
		pg <= pci_out.req;
		pa <= pci_out.req && !(slow && pa);
		pab <= pci_out.req ? abort_kind : 2'h0;
		prd <= pg ? pci_out.addr : ~prd;
	end
	assign pci_in = {pclk, pg, pa, pab[0], pab[1], prd};
	// Grant one cycle late; slow mode acknowledges every other cycle
	always @(posedge clk) begin
		gq <= mem_out.req;
		tick <= !tick;
		if (clr)
			mem_cnt <= 32'h0;
		else if (mem_out.req && mem_in.gnt && mem_in.ack)
			mem_cnt <= mem_cnt + 32'h1;
	end
	assign mack = gq && !(slow && tick);
	assign mem_in = {gq, mack, mack ? mem_out.addr : ~mem_out.addr};
endmodule : pmd_far_model
`default_nettype wire

// >>> tb/pmd_dma_tb_top.sv
// Self-checking bench of the DMA engine
`timescale 1ns/1ps
`default_nettype none
module pmd_dma_tb_top
	import pmd_pkg::*;
;
	logic clk = 1'b0, srst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, mcnt;
	pmd_pci_in_t pci_in;
	pmd_pci_out_t pci_out;
	pmd_mem_in_t mem_in;
	pmd_mem_out_t mem_out;
	logic msw = 1'b0, cmr = 1'b0, cwp = 1'b0, cmt = 1'b0, cpr = 1'b0, pmb = 1'b0;
	logic crdy = 1'b1, done_n, win, berr, eseen = 1'b0, slow = 1'b0, clr = 1'b0;
	logic [3:0] cdone, dseen = 4'h0;
	logic [1:0] btype, abk = 2'h0;
	int miscompares = 0, checks_done = 0;
	pmd_dma dut (.clk, .srst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pci_in, .pci_out, .mem_in, .mem_out, .mem_single_word(msw), .cpu_mem_rd_req(cmr),
		.cpu_wfifo_posted(cwp), .cpu_mem_taken(cmt), .cpu_pci_rd_req(cpr),
		.pci_mfifo_busy(pmb), .cpu_ready(crdy), .cpu_cycle_done_n(done_n),
		.cpu_mem_window(win), .chan_done(cdone), .bus_error(berr), .bus_error_type(btype));
	pmd_far_model far (.clk, .slow, .clr, .abort_kind(abk), .pci_out, .mem_out, .pci_in,
		.mem_in, .mem_cnt(mcnt));
	initial begin
		forever #4 clk = !clk;
	end
	// The CPU takes its window as soon as it opens
	always @(posedge clk) begin
		cmt <= cmr && win && !cmt;
		// Scenarios clear the memory count and these flags together
		dseen <= clr ? 4'h0 : (dseen | cdone);
		eseen <= clr ? 1'b0 : (eseen | berr);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic wait_idle(input logic [7:0] a, output logic [31:0] v);
		v = 32'hFFFF_FFFF;
		for (int i = 0; i < 2000 && v[CTL_BUSY] !== 1'b0; i++)
			rd(a, v);
		check("busy", v[CTL_BUSY], 32'h0);
	endtask : wait_idle
	task automatic t_reset_vals();
		logic [7:0] ofs[6] = '{OFS_CTL0, OFS_CTL1, OFS_CTL2, OFS_CTL3, OFS_CHAIN, 8'h00};
		logic [31:0] v;
		foreach (ofs[i]) begin
			rd(ofs[i], v);
			check("reset value", v, 32'h0);
		end
	endtask : t_reset_vals
	task automatic t_m2p();
		logic [31:0] v;
		clr <= 1'b1;
		slow <= 1'b1;
		wr(OFS_MADDR0, 32'h0000_1000);
		clr <= 1'b0;
		wr(OFS_PADDR0, 32'h0020_0000);
		wr(OFS_CTL0, 32'h5410_0040);
		cmr <= 1'b1;
		cpr <= 1'b1;
		pmb <= 1'b1;
		rd(OFS_CTL0, v);
		check("busy ctl", v, 32'hD410_0040);
		check("cpu stall", {31'h0, done_n}, 32'h1);
		// Clearing go and a new length must both be ignored while running
		wr(OFS_CTL0, 32'h0000_0008);
		rd(OFS_CTL0, v);
		check("locked ctl", v, 32'hD410_0040);
		cpr <= 1'b0;
		pmb <= 1'b0;
		wait_idle(OFS_CTL0, v);
		check("cpu free", {30'h0, win, done_n}, 32'h2);
		cmr <= 1'b0;
		slow <= 1'b0;
		check("ctl end", v, 32'h4410_0040);
		check("mem words", mcnt, 32'd16);
		check("mem addr", mem_out.addr, 32'h0000_1040);
		check("pci addr", pci_out.addr, 32'h0020_0040);
		check("done", {28'h0, dseen}, 32'h1);
	endtask : t_m2p
	task automatic t_p2m();
		logic [31:0] v;
		clr <= 1'b1;
		wr(OFS_MADDR0 + OFS_STRIDE, 32'h0000_2000);
		clr <= 1'b0;
		wr(OFS_PADDR0 + OFS_STRIDE, 32'h0030_0000);
		wr(OFS_CTL1, 32'h3400_0020);
		wait_idle(OFS_CTL1, v);
		check("mem words", mcnt, 32'd8);
		check("mem addr", mem_out.addr, 32'h0000_2020);
		check("no done", {28'h0, dseen}, 32'h0);
	endtask : t_p2m
	task automatic t_abort();
		logic [7:0] ca[3] = '{OFS_CTL2, OFS_CTL2, OFS_CTL3};
		logic [31:0] v;
		for (int k = 0; k < 3; k++) begin
			clr <= 1'b1;
			wr(ca[k], 32'h5400_0400);
			clr <= 1'b0;
			for (int i = 0; i < 300 && pci_out.req !== 1'b1; i++)
				@(posedge clk);
			if (k == 0)
				wr(ca[k], 32'h0100_0000);
			else
				abk <= k[1:0];
			wait_idle(ca[k], v);
			abk <= 2'h0;
			check("no done", {28'h0, dseen}, 32'h0);
			check("error seen", eseen, k != 0);
			if (k != 0)
				check("error type", btype, k);
		end
	endtask : t_abort
	// Memory echoes its address, so each fetched record points on; chaining is cut after one
	task automatic t_chain();
		logic [31:0] v;
		clr <= 1'b1;
		wr(OFS_MADDR0 + 8'h30, 32'h0000_4000);
		clr <= 1'b0;
		wr(OFS_PADDR0 + 8'h30, 32'h0050_0000);
		wr(OFS_NEXT0 + 8'h30, 32'h0000_0010);
		wr(OFS_CHAIN, 32'h0000_0800);
		wr(OFS_CTL3, 32'h5000_0010);
		v = 32'h0;
		for (int i = 0; i < 500 && v !== 32'h0000_001C; i++)
			rd(OFS_NEXT0 + 8'h30, v);
		wr(OFS_CHAIN, 32'h0000_0000);
		wait_idle(OFS_CTL3, v);
		check("chain ctl", v, 32'h0000_0010);
		rd(OFS_MADDR0 + 8'h30, v);
		check("chain maddr", v, 32'h0000_0014);
		check("chain words", mcnt, 32'd12);
		check("chain addr", mem_out.addr, 32'h0000_0024);
		check("chain done", {28'h0, dseen}, 32'h0);
	endtask : t_chain
	task automatic give_verdict();
		$display("checks_done %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		t_reset_vals();
		t_m2p();
		t_p2m();
		t_abort();
		t_chain();
		give_verdict();
	end
	// Far beyond the few thousand cycles the scenarios need
	initial begin
		#400000;
		miscompares++;
		give_verdict();
	end
endmodule : pmd_dma_tb_top
bind pmd_dma pmd_dma_props u_props (.clk, .srst, .reg_rd, .reg_rdata, .pci_out, .mem_out,
	.cpu_mem_rd_req, .cpu_wfifo_posted, .cpu_pci_rd_req, .pci_mfifo_busy, .cpu_ready,
	.cpu_cycle_done_n, .cpu_mem_window, .chan_done, .bus_error, .bus_error_type);
`default_nettype wire
